// ==== src/autoneg_partner_pkg.sv ====
package autoneg_partner_pkg;

  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 5;

  // Management register addresses
  localparam logic [ADDR_W-1:0] ADDR_LP_ABILITY = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_EXPANSION  = 5'h06;

  // Partner ability field positions
  localparam int unsigned LPA_NEXT_PAGE   = 15;
  localparam int unsigned LPA_ACK         = 14;
  localparam int unsigned LPA_REMOTE_FLT  = 13;
  localparam int unsigned LPA_RSVD_HI     = 12;
  localparam int unsigned LPA_RSVD_LO     = 11;
  localparam int unsigned LPA_PAUSE       = 10;
  localparam int unsigned LPA_T4          = 9;
  localparam int unsigned LPA_FAST_FDX    = 8;
  localparam int unsigned LPA_FAST_HDX    = 7;
  localparam int unsigned LPA_TEN_FDX     = 6;
  localparam int unsigned LPA_TEN_HDX     = 5;
  localparam int unsigned LPA_SEL_HI      = 4;
  localparam int unsigned LPA_SEL_LO      = 0;
  localparam int unsigned SEL_W           = LPA_SEL_HI - LPA_SEL_LO + 1;

  // Expansion field positions
  localparam int unsigned EXP_PAR_FAULT   = 4;
  localparam int unsigned EXP_LP_NP_CAP   = 3;
  localparam int unsigned EXP_LOC_NP_CAP  = 2;
  localparam int unsigned EXP_PAGE_RX     = 1;
  localparam int unsigned EXP_LP_AN_CAP   = 0;

  // Reset and fixed values
  localparam logic [REG_W-1:0] REG_ZERO       = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET      = 5'h00;
  localparam logic             LOC_NP_CAP_VAL = 1'b0;

endpackage

// ==== src/latched_high_flag.sv ====
`timescale 1ns/1ps
// Sticky flag: set by hardware, cleared by a management read; set wins
module latched_high_flag (
  input  wire logic i_core_clk,  // Core clock
  input  wire logic i_rst,       // Async reset, active high
  input  wire logic i_set,       // Set pulse from event source
  input  wire logic i_clr,       // Clear pulse on register read
  output logic      o_flag       // Latched flag
);

  // A set in the clear cycle must not be lost, so set has priority
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end

endmodule

// ==== src/autoneg_partner_status.sv ====
`timescale 1ns/1ps
// Partner ability and expansion status registers
module autoneg_partner_status (
  input  wire logic                                   i_core_clk,        // Core clock 200 MHz
  input  wire logic                                   i_rst,             // Async reset, high
  // Auto-negotiation engine side
  input  wire logic                                   i_page_valid,      // Base page received
  input  wire logic [autoneg_partner_pkg::REG_W-1:0]  i_page_word,       // Received code word
  input  wire logic                                   i_partner_an_cap,  // Partner does autoneg
  input  wire logic                                   i_par_fault,       // Parallel detect fault
  input  wire logic                                   i_link_restart,    // Clear partner data
  // Management register port
  input  wire logic                                   i_mgmt_rd,         // Read strobe
  input  wire logic                                   i_mgmt_wr,         // Write strobe
  input  wire logic [autoneg_partner_pkg::ADDR_W-1:0] i_mgmt_addr,       // Register address
  input  wire logic [autoneg_partner_pkg::REG_W-1:0]  i_mgmt_wdata,      // Write data
  output logic      [autoneg_partner_pkg::REG_W-1:0]  o_mgmt_rdata,      // Read data
  output logic                                        o_mgmt_rvalid,     // Read data valid
  output logic                                        o_mgmt_hit,        // Address mapped here
  // Status toward the PHY core
  output logic      [autoneg_partner_pkg::REG_W-1:0]  o_lp_ability,      // Partner abilities
  output logic                                        o_page_rx          // Page received flag
);
  import autoneg_partner_pkg::*;

  logic             partner_next_page_r;
  logic             partner_ack_r;
  logic             remote_fault_flag_r;
  logic             pause_capability_r;
  logic             t4_cap_r;
  logic             fast_full_duplex_cap_r;
  logic             fast_half_duplex_cap_r;
  logic             ten_full_duplex_cap_r;
  logic             ten_half_duplex_cap_r;
  logic [SEL_W-1:0] selector_r;
  logic             partner_autoneg_cap_r;
  logic             parallel_detect_fault;
  logic             page_rx_flag;
  logic             rd_lpa;
  logic             rd_exp;
  logic             wr_lpa;
  logic [REG_W-1:0] lpa_word;
  logic [REG_W-1:0] exp_word;
  logic [REG_W-1:0] rdata_nxt;

  // Address decode for the two registers
  assign rd_lpa = i_mgmt_rd && (i_mgmt_addr == ADDR_LP_ABILITY);
  assign rd_exp = i_mgmt_rd && (i_mgmt_addr == ADDR_EXPANSION);
  assign wr_lpa = i_mgmt_wr && (i_mgmt_addr == ADDR_LP_ABILITY);

  // Read-only partner fields load from each received base page
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      partner_next_page_r    <= 1'b0;
      partner_ack_r          <= 1'b0;
      remote_fault_flag_r    <= 1'b0;
      t4_cap_r               <= 1'b0;
      fast_full_duplex_cap_r <= 1'b0;
      fast_half_duplex_cap_r <= 1'b0;
      ten_full_duplex_cap_r  <= 1'b0;
      ten_half_duplex_cap_r  <= 1'b0;
      selector_r             <= SEL_RESET;
    end else if (i_link_restart) begin
      partner_next_page_r    <= 1'b0;
      partner_ack_r          <= 1'b0;
      remote_fault_flag_r    <= 1'b0;
      t4_cap_r               <= 1'b0;
      fast_full_duplex_cap_r <= 1'b0;
      fast_half_duplex_cap_r <= 1'b0;
      ten_full_duplex_cap_r  <= 1'b0;
      ten_half_duplex_cap_r  <= 1'b0;
      selector_r             <= SEL_RESET;
    end else if (i_page_valid) begin
      partner_next_page_r    <= i_page_word[LPA_NEXT_PAGE];
      partner_ack_r          <= i_page_word[LPA_ACK];
      remote_fault_flag_r    <= i_page_word[LPA_REMOTE_FLT];
      t4_cap_r               <= i_page_word[LPA_T4];
      fast_full_duplex_cap_r <= i_page_word[LPA_FAST_FDX];
      fast_half_duplex_cap_r <= i_page_word[LPA_FAST_HDX];
      ten_full_duplex_cap_r  <= i_page_word[LPA_TEN_FDX];
      ten_half_duplex_cap_r  <= i_page_word[LPA_TEN_HDX];
      selector_r             <= i_page_word[LPA_SEL_HI:LPA_SEL_LO];
    end
  end

  // Pause bit is writable; a fresh page overrides a write in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pause_capability_r <= 1'b0;
    end else if (i_link_restart) begin
      pause_capability_r <= 1'b0;
    end else if (i_page_valid) begin
      pause_capability_r <= i_page_word[LPA_PAUSE];
    end else if (wr_lpa) begin
      pause_capability_r <= i_mgmt_wdata[LPA_PAUSE];
    end
  end

  // Partner autoneg ability tracks the engine's detection
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      partner_autoneg_cap_r <= 1'b0;
    end else begin
      partner_autoneg_cap_r <= i_partner_an_cap;
    end
  end

  // Parallel detection fault, cleared by reading the expansion register
  latched_high_flag u_par_fault (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_par_fault),
    .i_clr      (rd_exp),
    .o_flag     (parallel_detect_fault)
  );

  // New page received, cleared by reading the expansion register
  latched_high_flag u_page_rx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_set      (i_page_valid),
    .i_clr      (rd_exp),
    .o_flag     (page_rx_flag)
  );

  // Assemble partner word; reserved bits 12:11 read zero, writes dropped
  always_comb begin
    lpa_word                          = REG_ZERO;
    lpa_word[LPA_NEXT_PAGE]           = partner_next_page_r;
    lpa_word[LPA_ACK]                 = partner_ack_r;
    lpa_word[LPA_REMOTE_FLT]          = remote_fault_flag_r;
    lpa_word[LPA_PAUSE]               = pause_capability_r;
    lpa_word[LPA_T4]                  = t4_cap_r;
    lpa_word[LPA_FAST_FDX]            = fast_full_duplex_cap_r;
    lpa_word[LPA_FAST_HDX]            = fast_half_duplex_cap_r;
    lpa_word[LPA_TEN_FDX]             = ten_full_duplex_cap_r;
    lpa_word[LPA_TEN_HDX]             = ten_half_duplex_cap_r;
    lpa_word[LPA_SEL_HI:LPA_SEL_LO]   = selector_r;
  end

  // Assemble expansion word; local next page ability is hard zero
  always_comb begin
    exp_word                 = REG_ZERO;
    exp_word[EXP_PAR_FAULT]  = parallel_detect_fault;
    exp_word[EXP_LP_NP_CAP]  = partner_next_page_r;
    exp_word[EXP_LOC_NP_CAP] = LOC_NP_CAP_VAL;
    exp_word[EXP_PAGE_RX]    = page_rx_flag;
    exp_word[EXP_LP_AN_CAP]  = partner_autoneg_cap_r;
  end

  // Read mux; unmapped addresses return zero with hit low
  always_comb begin
    rdata_nxt = REG_ZERO;
    if (rd_lpa) begin
      rdata_nxt = lpa_word;
    end else if (rd_exp) begin
      rdata_nxt = exp_word;
    end
  end

  // Registered read answer, one cycle after the strobe; data holds until next read
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mgmt_rdata  <= REG_ZERO;
      o_mgmt_rvalid <= 1'b0;
      o_mgmt_hit    <= 1'b0;
    end else begin
      o_mgmt_rvalid <= i_mgmt_rd;
      if (i_mgmt_rd) begin
        o_mgmt_rdata <= rdata_nxt;
        o_mgmt_hit   <= rd_lpa || rd_exp;
      end
    end
  end

  // Status copies for the rest of the PHY, straight from flops
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lp_ability <= REG_ZERO;
      o_page_rx    <= 1'b0;
    end else begin
      o_lp_ability <= lpa_word;
      o_page_rx    <= page_rx_flag;
    end
  end

endmodule

// ==== testbench/autoneg_partner_status_asserts.sv ====
`timescale 1ns/1ps
// Protocol checks on the status block's ports
module autoneg_partner_status_asserts (
  input wire logic                                   i_core_clk,     // Clock
  input wire logic                                   i_rst,          // Reset
  input wire logic                                   i_page_valid,   // Page strobe
  input wire logic [autoneg_partner_pkg::REG_W-1:0]  i_page_word,    // Code word
  input wire logic                                   i_link_restart, // Restart
  input wire logic                                   i_mgmt_rd,      // Read strobe
  input wire logic [autoneg_partner_pkg::ADDR_W-1:0] i_mgmt_addr,    // Address
  input wire logic [autoneg_partner_pkg::REG_W-1:0]  o_mgmt_rdata,   // Read data
  input wire logic                                   o_mgmt_rvalid,  // Read valid
  input wire logic                                   o_mgmt_hit,     // Mapped
  input wire logic [autoneg_partner_pkg::REG_W-1:0]  o_lp_ability,   // Abilities
  input wire logic                                   o_page_rx       // Page flag
);
  import autoneg_partner_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Read answer comes exactly one cycle after the strobe, never otherwise
  a_rvalid_one_cycle: assert property (
    o_mgmt_rvalid == $past(i_mgmt_rd)) else $error("read valid timing wrong");
  a_hit_held_idle: assert property (
    !i_mgmt_rd |=> $stable(o_mgmt_hit) && $stable(o_mgmt_rdata)) else $error("answer moved");
  a_hit_mapped: assert property (
    i_mgmt_rd |=> o_mgmt_hit == ($past(i_mgmt_addr) == ADDR_LP_ABILITY
      || $past(i_mgmt_addr) == ADDR_EXPANSION)) else $error("hit decode wrong");
  a_unmapped_zero: assert property (
    o_mgmt_rvalid && !o_mgmt_hit |-> o_mgmt_rdata == 16'h0000) else $error("unmapped data");
  a_rsvd_bits_zero: assert property (
    o_lp_ability[LPA_RSVD_HI:LPA_RSVD_LO] == 2'h0) else $error("reserved bits set");
  // Pause bit and reserved bits 12:11 are left out; the reserved bits read zero whatever the page carries
  a_page_load: assert property (
    i_page_valid && !i_link_restart ##1 !i_page_valid && !i_link_restart
      |=> (o_lp_ability & 16'hE3FF) == ($past(i_page_word, 2) & 16'hE3FF))
    else $error("page not loaded");
  a_page_rx_set: assert property (
    i_page_valid |-> ##2 o_page_rx) else $error("page flag not set");
  a_page_rx_clear: assert property (
    i_mgmt_rd && i_mgmt_addr == ADDR_EXPANSION && !i_page_valid |-> ##2 !o_page_rx)
    else $error("page flag not cleared");
  a_local_np_zero: assert property (
    o_mgmt_rvalid && o_mgmt_hit && $past(i_mgmt_addr) == ADDR_EXPANSION
      |-> !o_mgmt_rdata[EXP_LOC_NP_CAP]) else $error("local next page set");
endmodule

bind autoneg_partner_status autoneg_partner_status_asserts autoneg_partner_status_asserts_i (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_page_valid(i_page_valid),
  .i_page_word(i_page_word), .i_link_restart(i_link_restart), .i_mgmt_rd(i_mgmt_rd),
  .i_mgmt_addr(i_mgmt_addr), .o_mgmt_rdata(o_mgmt_rdata), .o_mgmt_rvalid(o_mgmt_rvalid),
  .o_mgmt_hit(o_mgmt_hit), .o_lp_ability(o_lp_ability), .o_page_rx(o_page_rx));

// ==== testbench/remote_link_partner.sv ====
`timescale 1ns/1ps
// Far end of the twisted pair, delivering decoded base pages
module remote_link_partner (
  input  wire logic                                  i_core_clk,   // Core clock
  output logic                                       o_page_valid, // Page strobe
  output logic      [autoneg_partner_pkg::REG_W-1:0] o_page_word,  // Code word
  output logic                                       o_an_cap      // Autoneg able
);
  initial begin
    o_page_valid = 1'h0;
    o_page_word  = 16'hA5A5;
    o_an_cap     = 1'h0;
  end
  // Word line shows the inverse outside the strobe so stale data never looks valid
  task automatic send(input logic [autoneg_partner_pkg::REG_W-1:0] w, input logic an);
    @(posedge i_core_clk);
    #1;
    o_page_valid = 1'h1;
    o_page_word  = w;
    o_an_cap     = an;
    @(posedge i_core_clk);
    #1;
    o_page_valid = 1'h0;
    o_page_word  = ~w;
  endtask
endmodule

// ==== testbench/autoneg_partner_status_tb_top.sv ====
`timescale 1ns/1ps
module autoneg_partner_status_tb_top;
  import autoneg_partner_pkg::*;
  logic              i_core_clk, i_rst, i_par_fault, i_link_restart, i_mgmt_rd, i_mgmt_wr;
  logic              page_valid, an_cap, o_mgmt_rvalid, o_mgmt_hit, o_page_rx, pf, prx;
  logic [ADDR_W-1:0] i_mgmt_addr;
  logic [REG_W-1:0]  i_mgmt_wdata, page_word, o_mgmt_rdata, o_lp_ability, lpa, w;
  logic [REG_W:0]    exp_q[$];
  int                num_errors, n_compared, cyc;

  initial begin
    i_core_clk = 1'h0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  autoneg_partner_status autoneg_partner_status_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_page_valid(page_valid), .i_page_word(page_word), .i_partner_an_cap(an_cap),
    .i_par_fault(i_par_fault), .i_link_restart(i_link_restart), .i_mgmt_rd(i_mgmt_rd),
    .i_mgmt_wr(i_mgmt_wr), .i_mgmt_addr(i_mgmt_addr), .i_mgmt_wdata(i_mgmt_wdata),
    .o_mgmt_rdata(o_mgmt_rdata), .o_mgmt_rvalid(o_mgmt_rvalid), .o_mgmt_hit(o_mgmt_hit),
    .o_lp_ability(o_lp_ability), .o_page_rx(o_page_rx));
  remote_link_partner remote_link_partner_i (.i_core_clk(i_core_clk),
    .o_page_valid(page_valid), .o_page_word(page_word), .o_an_cap(an_cap));

  task automatic check(input logic [REG_W:0] got, input logic [REG_W:0] want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d of %0d compares", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read strobe held into the next cycle; sticky flags drop in the model once read
  task automatic rd(input logic [ADDR_W-1:0] a);
    i_mgmt_rd = 1'h1;
    i_mgmt_wr = 1'h0;
    i_mgmt_addr = a;
    if (a == ADDR_LP_ABILITY) exp_q.push_back({1'h1, lpa});
    else if (a == ADDR_EXPANSION) exp_q.push_back({1'h1, 11'h000, pf, lpa[15], 1'h0, prx, an_cap});
    else exp_q.push_back(17'h0_0000);
    if (a == ADDR_EXPANSION) {pf, prx} = 2'h0;
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    i_mgmt_wr = 1'h1;
    i_mgmt_rd = 1'h0;
    i_mgmt_addr = a;
    i_mgmt_wdata = d;
    if (a == ADDR_LP_ABILITY) lpa[LPA_PAUSE] = d[LPA_PAUSE];
    @(posedge i_core_clk);
    #1;
  endtask

  task automatic idle;
    i_mgmt_rd = 1'h0;
    i_mgmt_wr = 1'h0;
    @(posedge i_core_clk);
    #1;
  endtask

  // Answer monitor on the falling edge, so rvalid and its data are seen while they stand
  // together; at the rising edge a back-to-back read would already have replaced the data
  always @(negedge i_core_clk) begin
    if (o_mgmt_rvalid === 1'h1) check({o_mgmt_hit, o_mgmt_rdata}, exp_q.pop_front());
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    {i_rst, i_par_fault, i_link_restart, i_mgmt_rd, i_mgmt_wr, pf, prx} = 7'h40;
    i_mgmt_addr = 5'h00;
    i_mgmt_wdata = 16'h0000;
    lpa = 16'h0000;
    void'($urandom(75));
    repeat (5) @(posedge i_core_clk);
    #1 i_rst = 1'h0;
    rd(ADDR_LP_ABILITY);
    rd(ADDR_EXPANSION);
    rd(5'h07);
    idle();
    for (int k = 0; k < 6; k++) begin
      w = $urandom;
      remote_link_partner_i.send(w, k[0]);
      i_par_fault = w[0];
      lpa = w & 16'hE7FF;
      prx = 1'h1;
      pf = pf | w[0];
      idle();
      i_par_fault = 1'h0;
      idle();
      check({1'h0, o_lp_ability}, {1'h0, lpa});
      check({16'h0000, o_page_rx}, 17'h0_0001);
      wr(ADDR_LP_ABILITY, 16'(~w));
      wr(ADDR_EXPANSION, 16'hFFFF);
      rd(ADDR_LP_ABILITY);
      rd(ADDR_EXPANSION);
      idle();
      rd(ADDR_EXPANSION);
      idle();
    end
    i_link_restart = 1'h1;
    idle();
    i_link_restart = 1'h0;
    lpa = 16'h0000;
    rd(ADDR_LP_ABILITY);
    rd(ADDR_EXPANSION);
    idle();
    repeat (3) @(posedge i_core_clk);
    stop_test();
  end
endmodule
